// >>> prcs_pkg.sv
// shared constants for the reference clock switchover block
package prcs_pkg;

  // register byte offsets
  localparam logic [7:0] PRCS_CTRL_OFS = 8'h00;
  localparam logic [7:0] PRCS_STATUS_OFS = 8'h04;
  localparam logic [7:0] PRCS_DIV_FIRST_OFS = 8'h08;
  localparam logic [7:0] PRCS_DIV_LAST_OFS = 8'h10;
  localparam logic [7:0] PRCS_ROUTE_OFS = 8'h14;

  // control register fields
  localparam int PRCS_CTRL_AUTO_BIT = 0;
  localparam int PRCS_CTRL_MANUAL_BIT = 1;
  localparam int PRCS_CTRL_KIND_LSB = 2;
  localparam logic PRCS_CTRL_AUTO_RESET = 1'b1;

  // reference source kinds
  localparam logic [1:0] PRCS_KIND_PIN = 2'h0;
  localparam logic [1:0] PRCS_KIND_CTRL_BLOCK = 2'h1;
  localparam logic [1:0] PRCS_KIND_INTERNAL = 2'h2;

  // status register fields
  localparam int PRCS_STAT_PRI_LOSS_BIT = 0;
  localparam int PRCS_STAT_SEC_LOSS_BIT = 1;
  localparam int PRCS_STAT_ACTIVE_BIT = 2;
  localparam int PRCS_STAT_BUSY_BIT = 3;
  localparam int PRCS_STAT_CFGERR_BIT = 4;

  // divider register fields
  localparam int PRCS_DIV_COUNT_W = 10;
  localparam int PRCS_DIV_DUTY_BIT = 10;
  localparam int PRCS_DIV_PHASE_LSB = 11;
  localparam int PRCS_PHASE_STEPS = 8;
  localparam int PRCS_PHASE_W = $clog2(PRCS_PHASE_STEPS);
  localparam logic [9:0] PRCS_DIV_MIN = 10'h001;
  localparam logic [9:0] PRCS_DIV_MAX_HALF = 10'h200;
  localparam logic [9:0] PRCS_DIV_MAX_OTHER = 10'h100;
  localparam logic [9:0] PRCS_DIV_RESET = 10'h001;
  localparam int PRCS_NUM_DIV = 3;

  // transmit routing enables, one per divider
  localparam int PRCS_ROUTE_SERIAL_BIT = 0;
  localparam int PRCS_ROUTE_LOAD_BIT = 1;
  localparam int PRCS_ROUTE_PARALLEL_BIT = 2;

  // loss detection timing
  localparam int PRCS_LOSS_REF_PERIODS = 2;
  localparam int PRCS_REF_PERIOD_CYCLES = 4;

  // switchover state machine
  typedef enum logic [1:0] {
    PRCS_SW_IDLE,
    PRCS_SW_GATE,
    PRCS_SW_TAKE
  } prcs_sw_state_t;

endpackage

// >>> prcs_loss_detect.sv
// low-level loss detector for one sampled reference clock
`timescale 1ns/100ps
`default_nettype none
module prcs_loss_detect
  import prcs_pkg::*;
#(
  parameter int LOSS_CYCLES = PRCS_LOSS_REF_PERIODS * PRCS_REF_PERIOD_CYCLES
) (
  // clock and reset
  input wire logic clock,
  input wire logic sys_rst,
  // sampled reference level
  input wire logic refLevel,
  // loss indication
  output logic lossFlag
);

  localparam int CNT_W = $clog2(LOSS_CYCLES + 1);
  localparam logic [CNT_W-1:0] CNT_LIMIT = CNT_W'(LOSS_CYCLES);

  logic [CNT_W-1:0] lowCount; // cycles spent low

  // count low time, restart on any high sample
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      lowCount <= '0;
    end else if (refLevel) begin
      lowCount <= '0;
    end else if (lowCount != CNT_LIMIT) begin
      lowCount <= lowCount + 1'b1;
    end
  end

  // flag once the input stayed low too long, drop when it toggles again
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      lossFlag <= 1'b0;
    end else if (refLevel) begin
      lossFlag <= 1'b0;
    end else if (lowCount == CNT_LIMIT) begin
      lossFlag <= 1'b1;
    end
  end

endmodule
`default_nettype wire

// >>> prcs_switchover.sv
// reference clock selection, glitch-free switchover and divider settings
//
// Added by the designer: the Avalon-MM register port and the address map.
`timescale 1ns/100ps
`default_nettype none
module prcs_switchover
  import prcs_pkg::*;
#(
  parameter int REF_PERIOD_CYCLES = PRCS_REF_PERIOD_CYCLES
) (
  // clock and reset
  input wire logic clock,
  input wire logic sys_rst,
  // reference clock inputs, sampled
  input wire logic primaryRefClock,
  input wire logic secondaryRefClock,
  // user switch request
  input wire logic manualSwitchRequest,
  // loop reference and indicators
  output logic loopRefClock,
  output logic activeClock,
  output logic primaryLossFlag,
  output logic secondaryLossFlag,
  // avalon-mm slave
  input wire logic [7:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [31:0] writedata,
  output logic [31:0] readdata,
  output logic waitrequest
);

  // divider value legal for the configured duty cycle
  function automatic logic divLegal(input logic [9:0] value, input logic halfDuty);
    logic [9:0] upper;
    upper = halfDuty ? PRCS_DIV_MAX_HALF : PRCS_DIV_MAX_OTHER;
    divLegal = (value >= PRCS_DIV_MIN) && (value <= upper);
  endfunction

  // register address inside the divider window, word aligned
  function automatic logic isDivAddr(input logic [7:0] addr);
    isDivAddr = (addr >= PRCS_DIV_FIRST_OFS) && (addr <= PRCS_DIV_LAST_OFS)
      && (addr[1:0] == 2'h0);
  endfunction

  // sampled reference levels and previous samples
  logic priLevel;
  logic secLevel;
  logic priPrev;
  logic secPrev;
  logic priFall;
  logic secFall;
  // manual request edge detection
  logic manualPrev;
  logic manualEdge;
  // control state
  logic autoEnable;
  logic softSwitch;
  logic [1:0] refKind;
  logic cfgError;
  logic [PRCS_DIV_COUNT_W-1:0] divCount [PRCS_NUM_DIV];
  logic divHalfDuty [PRCS_NUM_DIV];
  logic [PRCS_PHASE_W-1:0] divPhase [PRCS_NUM_DIV];
  logic [2:0] routeEnable;
  // switchover state
  prcs_sw_state_t swState;
  logic selSecondary;
  logic gateOn;
  logic curFall;
  logic newFall;
  logic curLost;
  logic newLost;
  logic switchStart;
  // bus handshake
  logic busReq;
  logic busAck;
  logic writeTaken;
  logic rejectWrite;
  logic [1:0] divIndex;
  logic [31:0] next_readdata;

  // sample the reference inputs once
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      priLevel <= 1'b0;
      secLevel <= 1'b0;
      priPrev <= 1'b0;
      secPrev <= 1'b0;
    end else begin
      priLevel <= primaryRefClock;
      secLevel <= secondaryRefClock;
      priPrev <= priLevel;
      secPrev <= secLevel;
    end
  end

  // falling edges of each reference
  assign priFall = priPrev & ~priLevel;
  assign secFall = secPrev & ~secLevel;

  // loss detection on the primary reference
  prcs_loss_detect #(
    .LOSS_CYCLES(PRCS_LOSS_REF_PERIODS * REF_PERIOD_CYCLES)
  ) primaryDetect (
    .clock(clock),
    .sys_rst(sys_rst),
    .refLevel(priLevel),
    .lossFlag(primaryLossFlag)
  );

  // same detection on the secondary reference
  prcs_loss_detect #(
    .LOSS_CYCLES(PRCS_LOSS_REF_PERIODS * REF_PERIOD_CYCLES)
  ) secondaryDetect (
    .clock(clock),
    .sys_rst(sys_rst),
    .refLevel(secLevel),
    .lossFlag(secondaryLossFlag)
  );

  // manual request rising edge; the requester holds it long enough to be seen
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      manualPrev <= 1'b0;
    end else begin
      manualPrev <= manualSwitchRequest;
    end
  end

  assign manualEdge = manualSwitchRequest & ~manualPrev;

  // current and candidate source views
  assign curFall = selSecondary ? secFall : priFall;
  assign newFall = selSecondary ? priFall : secFall;
  assign curLost = selSecondary ? secondaryLossFlag : primaryLossFlag;
  assign newLost = selSecondary ? primaryLossFlag : secondaryLossFlag;

  // start on a manual edge, a software request, or loss of the current source
  assign switchStart = manualEdge | softSwitch
    | (autoEnable & curLost & ~newLost);

  // switchover state machine
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      swState <= PRCS_SW_IDLE;
    end else begin
      case (swState)
        PRCS_SW_IDLE: begin
          if (switchStart) begin
            swState <= PRCS_SW_GATE;
          end
        end
        PRCS_SW_GATE: begin
          // a dead source is already low, gate at once
          if (curFall | curLost) begin
            swState <= PRCS_SW_TAKE;
          end
        end
        PRCS_SW_TAKE: begin
          if (newFall) begin
            swState <= PRCS_SW_IDLE;
          end
        end
        default: begin
          swState <= PRCS_SW_IDLE;
        end
      endcase
    end
  end

  // output gate: closed on the old falling edge, reopened on the new one
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      gateOn <= 1'b1;
    end else if (swState == PRCS_SW_GATE && (curFall | curLost)) begin
      gateOn <= 1'b0;
    end else if (swState == PRCS_SW_TAKE && newFall) begin
      gateOn <= 1'b1;
    end
  end

  // multiplexer select, moved only while the output is gated
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      selSecondary <= 1'b0;
    end else if (swState == PRCS_SW_TAKE && newFall) begin
      selSecondary <= ~selSecondary;
    end
  end

  // registered loop reference and source indicator
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      loopRefClock <= 1'b0;
      activeClock <= 1'b0;
    end else begin
      loopRefClock <= gateOn & (selSecondary ? secLevel : priLevel);
      activeClock <= selSecondary;
    end
  end

  // bus: one wait cycle, answer on the second edge
  assign busReq = read | write;
  assign waitrequest = busReq & ~busAck;
  assign writeTaken = write & busAck;
  assign divIndex = 2'((address - PRCS_DIV_FIRST_OFS) >> 2);

  // acknowledge toggles so each request takes exactly two edges
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      busAck <= 1'b0;
    end else begin
      busAck <= busReq & ~busAck;
    end
  end

  // writes that break a configuration limit are dropped
  always_comb begin
    rejectWrite = 1'b0;
    if (address == PRCS_CTRL_OFS) begin
      rejectWrite = writedata[PRCS_CTRL_KIND_LSB+:2] == PRCS_KIND_INTERNAL
        || writedata[PRCS_CTRL_KIND_LSB+:2] > PRCS_KIND_INTERNAL;
    end else if (isDivAddr(address)) begin
      rejectWrite = ~divLegal(writedata[PRCS_DIV_COUNT_W-1:0],
        writedata[PRCS_DIV_DUTY_BIT]);
    end
  end

  // control register and one-shot software switch
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      autoEnable <= PRCS_CTRL_AUTO_RESET;
      softSwitch <= 1'b0;
      refKind <= PRCS_KIND_PIN;
    end else begin
      softSwitch <= 1'b0;
      if (writeTaken && address == PRCS_CTRL_OFS && !rejectWrite) begin
        autoEnable <= writedata[PRCS_CTRL_AUTO_BIT];
        softSwitch <= writedata[PRCS_CTRL_MANUAL_BIT];
        refKind <= writedata[PRCS_CTRL_KIND_LSB+:2];
      end
    end
  end

  // sticky configuration error, set wins over write-one-to-clear
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      cfgError <= 1'b0;
    end else if (writeTaken && rejectWrite) begin
      cfgError <= 1'b1;
    end else if (writeTaken && address == PRCS_STATUS_OFS
        && writedata[PRCS_STAT_CFGERR_BIT]) begin
      cfgError <= 1'b0;
    end
  end

  // output divider settings
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      for (int i = 0; i < PRCS_NUM_DIV; i++) begin
        divCount[i] <= PRCS_DIV_RESET;
        divHalfDuty[i] <= 1'b1;
        divPhase[i] <= '0;
      end
    end else if (writeTaken && isDivAddr(address) && !rejectWrite) begin
      divCount[divIndex] <= writedata[PRCS_DIV_COUNT_W-1:0];
      divHalfDuty[divIndex] <= writedata[PRCS_DIV_DUTY_BIT];
      // phase in eighths of the oscillator period
      divPhase[divIndex] <= writedata[PRCS_DIV_PHASE_LSB+:PRCS_PHASE_W];
    end
  end

  // transmit routing: three enable bits, stored and read back only, not used by any other logic
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      routeEnable <= 3'h0;
    end else if (writeTaken && address == PRCS_ROUTE_OFS) begin
      routeEnable <= writedata[2:0];
    end
  end

  // read mux
  always_comb begin
    next_readdata = 32'h0000_0000;
    if (address == PRCS_CTRL_OFS) begin
      next_readdata[PRCS_CTRL_AUTO_BIT] = autoEnable;
      next_readdata[PRCS_CTRL_KIND_LSB+:2] = refKind;
    end else if (address == PRCS_STATUS_OFS) begin
      next_readdata[PRCS_STAT_PRI_LOSS_BIT] = primaryLossFlag;
      next_readdata[PRCS_STAT_SEC_LOSS_BIT] = secondaryLossFlag;
      next_readdata[PRCS_STAT_ACTIVE_BIT] = activeClock;
      next_readdata[PRCS_STAT_BUSY_BIT] = swState != PRCS_SW_IDLE;
      next_readdata[PRCS_STAT_CFGERR_BIT] = cfgError;
    end else if (isDivAddr(address)) begin
      next_readdata[PRCS_DIV_COUNT_W-1:0] = divCount[divIndex];
      next_readdata[PRCS_DIV_DUTY_BIT] = divHalfDuty[divIndex];
      next_readdata[PRCS_DIV_PHASE_LSB+:PRCS_PHASE_W] = divPhase[divIndex];
    end else if (address == PRCS_ROUTE_OFS) begin
      next_readdata[PRCS_ROUTE_SERIAL_BIT] = routeEnable[PRCS_ROUTE_SERIAL_BIT];
      next_readdata[PRCS_ROUTE_LOAD_BIT] = routeEnable[PRCS_ROUTE_LOAD_BIT];
      next_readdata[PRCS_ROUTE_PARALLEL_BIT] = routeEnable[PRCS_ROUTE_PARALLEL_BIT];
    end
  end

  // read data registered on the wait cycle, valid when waitrequest drops
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      readdata <= 32'h0000_0000;
    end else if (read && !busAck) begin
      readdata <= next_readdata;
    end
  end

endmodule
`default_nettype wire

// >>> prcs_switchover_properties.sv
// port assertions for the reference clock switchover block
`timescale 1ns/100ps
`default_nettype none
module prcs_switchover_properties (
  // clock and reset
  input wire logic clock,
  input wire logic sys_rst,
  // references and request
  input wire logic primaryRefClock,
  input wire logic secondaryRefClock,
  input wire logic manualSwitchRequest,
  // loop side
  input wire logic loopRefClock,
  input wire logic activeClock,
  input wire logic primaryLossFlag,
  input wire logic secondaryLossFlag,
  // bus handshake
  input wire logic read,
  input wire logic write,
  input wire logic waitrequest
);
  logic [3:0] priLow; // low run of primary
  logic [3:0] secLow; // low run of secondary
  // saturating low-run counters
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      priLow <= 4'h0;
      secLow <= 4'h0;
    end else begin
      priLow <= primaryRefClock ? 4'h0 : priLow + {3'h0, priLow != 4'hf};
      secLow <= secondaryRefClock ? 4'h0 : secLow + {3'h0, secLow != 4'hf};
    end
  end
  default clocking cb @(posedge clock); endclocking
  default disable iff (sys_rst);
  a_pri_loss: assert property (priLow >= 4'hd |-> primaryLossFlag)
    else $error("primary loss flag missing");
  a_pri_early: assert property ($rose(primaryLossFlag) |-> priLow >= 4'h8)
    else $error("primary loss flag early");
  a_pri_clear: assert property ($rose(primaryRefClock) |-> ##4 !primaryLossFlag)
    else $error("primary loss flag stuck");
  a_sec_loss: assert property (secLow >= 4'hd |-> secondaryLossFlag)
    else $error("secondary loss flag missing");
  a_no_glitch: assert property ($changed(loopRefClock) |=> $stable(loopRefClock))
    else $error("loop reference glitch");
  a_gate_first: assert property ($changed(activeClock) |-> !$past(loopRefClock))
    else $error("select changed while passing high");
  a_manual_go: assert property ($rose(manualSwitchRequest) && !primaryLossFlag
    && !secondaryLossFlag |-> ##[1:40] $changed(activeClock))
    else $error("manual switch not done");
  a_auto_go: assert property ($rose(primaryLossFlag) && !activeClock
    && !secondaryLossFlag |-> ##[1:40] activeClock)
    else $error("automatic switch not done");
  a_wait_once: assert property ((read || write) && waitrequest |=> !waitrequest)
    else $error("wait state too long");
endmodule
`default_nettype wire

// >>> prcs_ref_model.sv
// reference clock sources and user switch request
`timescale 1ns/100ps
`default_nettype none
module prcs_ref_model (
  // clock
  input wire logic clock,
  // bench controls
  input wire logic priStop,
  input wire logic secStop,
  input wire logic manualGo,
  // to the block
  output logic primaryRefClock = 1'b0,
  output logic secondaryRefClock = 1'b0,
  output logic manualSwitchRequest = 1'b0
);
  logic [2:0] phase = 3'h0; // free-running divider
  logic [4:0] hold = 5'h0; // request hold count
  logic priRun = 1'b1; // primary allowed to toggle
  logic secRun = 1'b1; // secondary allowed to toggle
  // primary period 4, secondary period 8; a stopped source stays low
  // stop and restart only at a period boundary, so no high pulse is cut short
  always_ff @(posedge clock) begin
    phase <= phase + 3'h1;
    if (phase[1:0] == 2'h3) begin
      priRun <= !priStop;
    end
    if (phase == 3'h7) begin
      secRun <= !secStop;
    end
    primaryRefClock <= priRun && phase[1];
    secondaryRefClock <= secRun && phase[2];
  end
  // request held beyond three slow periods
  always_ff @(posedge clock) begin
    if (manualGo) begin
      hold <= 5'h1c;
    end else if (hold != 5'h0) begin
      hold <= hold - 5'h1;
    end
    manualSwitchRequest <= hold != 5'h0;
  end
endmodule
`default_nettype wire

// >>> prcs_switchover_tb.sv
// testbench for the reference clock switchover block
`timescale 1ns/100ps
`default_nettype none
module prcs_switchover_tb
  import prcs_pkg::*;
;
  logic clock, sys_rst, read, write, priStop, secStop, manualGo;
  logic [7:0] address;
  logic [31:0] writedata, rd;
  int failures = 0;
  int checkCount = 0;
  wire logic priRef, secRef, manReq, loopRefClock, activeClock;
  wire logic primaryLossFlag, secondaryLossFlag, waitrequest;
  wire logic [31:0] readdata;
  // register cases: address, write, readback
  logic [7:0] tA [9] = '{8'h08, 8'h0c, 8'h10, 8'h10, 8'h0c, 8'h0c, 8'h00, 8'h00, 8'h14};
  logic [15:0] tW [9] = '{16'h600, 16'h601, 16'h101, 16'h100, 16'h3c01, 16'h0, 16'h9,
    16'h5, 16'h7};
  logic [15:0] tR [9] = '{16'h600, 16'h401, 16'h401, 16'h100, 16'h3c01, 16'h3c01,
    16'h1, 16'h5, 16'h7};
  logic [0:8] tE = 9'b011001100; // refused write expected
  prcs_ref_model src (.clock(clock), .priStop(priStop), .secStop(secStop),
    .manualGo(manualGo), .primaryRefClock(priRef), .secondaryRefClock(secRef),
    .manualSwitchRequest(manReq));
  prcs_switchover #(.REF_PERIOD_CYCLES(4)) uut (.clock(clock), .sys_rst(sys_rst),
    .primaryRefClock(priRef), .secondaryRefClock(secRef), .manualSwitchRequest(manReq),
    .loopRefClock(loopRefClock), .activeClock(activeClock),
    .primaryLossFlag(primaryLossFlag), .secondaryLossFlag(secondaryLossFlag),
    .address(address), .read(read), .write(write), .writedata(writedata),
    .readdata(readdata), .waitrequest(waitrequest));
  // compare and count
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checkCount++;
    if (seen !== exp) begin
      failures++;
      $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  // verdict and end of run
  task automatic final_report();
    $display("checks %0d failures %0d", checkCount, failures);
    if (failures == 0 && checkCount > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  // one avalon transfer, held until waitrequest is sampled low at a rising edge
  task automatic busDo(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clock);
    read <= !wr;
    write <= wr;
    address <= a;
    writedata <= d;
    do begin
      @(posedge clock);
      n++;
    end while (waitrequest !== 1'b0 && n < 20);
    // answer taken at the very edge where waitrequest is seen low
    rd = readdata;
    read <= 1'b0;
    write <= 1'b0;
    if (waitrequest !== 1'b0) begin
      failures++;
      final_report();
    end
  endtask
  // wait for {secLoss, priLoss, active}
  task automatic waitObs(input logic [2:0] val);
    int n;
    n = 0;
    while ({secondaryLossFlag, primaryLossFlag, activeClock} !== val && n < 300) begin
      @(negedge clock);
      n++;
    end
    check({29'h0, secondaryLossFlag, primaryLossFlag, activeClock}, {29'h0, val});
    // a spent bound is a mismatch of its own
    if (n >= 300) begin
      failures++;
      final_report();
    end
  endtask
  // rising edges of the loop reference in 32 cycles
  task automatic countRise(input logic [31:0] exp);
    logic [31:0] n;
    logic last;
    n = 0;
    repeat (8) @(negedge clock);
    last = loopRefClock;
    repeat (32) begin
      @(negedge clock);
      if (loopRefClock && !last) n++;
      last = loopRefClock;
    end
    check(n, exp);
  endtask
  // manual request once the previous one has ended
  task automatic pulse();
    repeat (40) @(posedge clock);
    manualGo <= 1'b1;
    @(posedge clock);
    manualGo <= 1'b0;
  endtask
  initial begin
    clock = 1'b0;
    forever #12.5 clock = ~clock;
  end
  // main sequence
  initial begin
    sys_rst = 1'b1;
    read = 1'b0;
    write = 1'b0;
    address = 8'h0;
    writedata = 32'h0;
    priStop = 1'b0;
    secStop = 1'b0;
    manualGo = 1'b0;
    repeat (2) @(posedge clock);
    sys_rst <= 1'b0;
    busDo(1'b0, PRCS_CTRL_OFS, 32'h0);
    check(rd, 32'h1);
    busDo(1'b0, PRCS_DIV_FIRST_OFS, 32'h0);
    check(rd, 32'h401);
    busDo(1'b0, 8'h20, 32'h0);
    check(rd, 32'h0);
    for (int i = 0; i < 9; i++) begin
      busDo(1'b1, tA[i], {16'h0, tW[i]});
      busDo(1'b0, tA[i], 32'h0);
      check(rd, {16'h0, tR[i]});
      busDo(1'b0, PRCS_STATUS_OFS, 32'h0);
      check({31'h0, rd[PRCS_STAT_CFGERR_BIT]}, {31'h0, tE[i]});
      busDo(1'b1, PRCS_STATUS_OFS, 32'h10);
    end
    countRise(32'h8);
    pulse();
    waitObs(3'b001);
    countRise(32'h4);
    pulse();
    waitObs(3'b000);
    priStop <= 1'b1;
    waitObs(3'b011);
    busDo(1'b0, PRCS_STATUS_OFS, 32'h0);
    check({29'h0, rd[2:0]}, 32'h5);
    priStop <= 1'b0;
    waitObs(3'b001);
    secStop <= 1'b1;
    waitObs(3'b100);
    secStop <= 1'b0;
    waitObs(3'b000);
    busDo(1'b1, PRCS_CTRL_OFS, 32'h7);
    waitObs(3'b001);
    final_report();
  end
endmodule
bind prcs_switchover prcs_switchover_properties chk (.clock(clock), .sys_rst(sys_rst),
  .primaryRefClock(primaryRefClock), .secondaryRefClock(secondaryRefClock),
  .manualSwitchRequest(manualSwitchRequest), .loopRefClock(loopRefClock),
  .activeClock(activeClock), .primaryLossFlag(primaryLossFlag),
  .secondaryLossFlag(secondaryLossFlag), .read(read), .write(write),
  .waitrequest(waitrequest));
`default_nettype wire
